// File: rtl/iocfp_decode.sv
// Purpose: Splits an instruction word and checks that it is addressed to us.
// Assumes: Any device code; the zero and all-ones codes never give a hit.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module iocfp_decode (
  // Instruction and identity
  input  wire logic [15:0]               instr,
  input  wire logic [5:0]                devcode,
  // Decoded fields
  output logic                           hit,
  output iocfp_pkg::iocfp_opcode_type    opcode,
  output logic [1:0]                     fcmd,
  output logic [1:0]                     acc_sel
);

  logic is_io;

  assign is_io   = instr[iocfp_pkg::IO_ID_MSB:iocfp_pkg::IO_ID_LSB]
                   == iocfp_pkg::IO_PATTERN;
  assign hit     = is_io && (instr[iocfp_pkg::DEV_MSB:iocfp_pkg::DEV_LSB] == devcode)
                   && (devcode != iocfp_pkg::DEV_NONE)
                   && (devcode != iocfp_pkg::DEV_CPU);
  assign opcode  = iocfp_pkg::iocfp_opcode_type'(
                     instr[iocfp_pkg::OPCODE_MSB:iocfp_pkg::OPCODE_LSB]);
  assign fcmd    = instr[iocfp_pkg::FLAG_MSB:iocfp_pkg::FLAG_LSB];
  assign acc_sel = instr[iocfp_pkg::ACC_SEL_MSB:iocfp_pkg::ACC_SEL_LSB];

endmodule // iocfp_decode

// File: rtl/iocfp_pkg.sv
// Purpose: Shared constants for the I/O controller flag port.
// Assumes: Instruction bit 15 is the most significant bit of the 16-bit word.
// Notes:   Register offsets are byte addresses on a 32-bit APB.
package iocfp_pkg;

  // Instruction word fields, LSB-numbered positions
  localparam logic [2:0] IO_PATTERN   = 3'h3;
  localparam int         IO_ID_MSB    = 15;
  localparam int         IO_ID_LSB    = 13;
  localparam int         ACC_SEL_MSB  = 12;
  localparam int         ACC_SEL_LSB  = 11;
  localparam int         OPCODE_MSB   = 10;
  localparam int         OPCODE_LSB   = 8;
  localparam int         FLAG_MSB     = 7;
  localparam int         FLAG_LSB     = 6;
  localparam int         DEV_MSB      = 5;
  localparam int         DEV_LSB      = 0;

  // Device codes nobody may claim
  localparam logic [5:0] DEV_NONE     = 6'h00;
  localparam logic [5:0] DEV_CPU      = 6'h3f;

  typedef enum logic [2:0] {
    flag_command_only     = 3'h0,
    read_input_buffer_a   = 3'h1,
    write_output_buffer_a = 3'h2,
    read_input_buffer_b   = 3'h3,
    write_output_buffer_b = 3'h4,
    read_input_buffer_c   = 3'h5,
    write_output_buffer_c = 3'h6,
    skip_on_flag_test     = 3'h7
  } iocfp_opcode_type;

  typedef enum logic [1:0] {
    FLAG_NONE  = 2'h0,
    FLAG_START = 2'h1,
    FLAG_CLEAR = 2'h2,
    FLAG_PULSE = 2'h3
  } iocfp_flag_type;

  typedef enum logic [1:0] {
    test_busy_set   = 2'h0,
    test_busy_clear = 2'h1,
    test_done_set   = 2'h2,
    test_done_clear = 2'h3
  } iocfp_test_type;

  // APB register offsets
  localparam logic [7:0] ADDR_INSTR   = 8'h00;
  localparam logic [7:0] ADDR_ACC_OUT = 8'h04;
  localparam logic [7:0] ADDR_ACC_IN  = 8'h08;
  localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
  localparam logic [7:0] ADDR_DEVCODE = 8'h10;

  // FLAGS register bits
  localparam int FLG_BUSY     = 0;
  localparam int FLG_DONE     = 1;
  localparam int FLG_SKIP     = 2;
  localparam int FLG_PASS_ERR = 3;
  localparam int FLG_ACT_ERR  = 4;
  localparam int FLG_PEND     = 5;
  localparam int FLG_ACC_LSB  = 6;

  // Status word layout, read through input buffer C
  localparam int STW_ACT_ERR  = 0;
  localparam int STW_PASS_ERR = 1;
  localparam int STW_EXT_LSB  = 2;
  localparam int STW_EXT_W    = 14;

endpackage

// File: rtl/iocfp_status.sv
// Purpose: Busy/done test evaluation and status word assembly.
// Assumes: Flags come straight from the controller state.
// Notes:   Purely combinational.
`timescale 1ns/1ps
module iocfp_status (
  // Flags
  input  wire logic                              busy,
  input  wire logic                              done,
  input  wire logic                              act_err,
  input  wire logic                              pass_err,
  input  wire logic [1:0]                        test,
  input  wire logic [iocfp_pkg::STW_EXT_W-1:0]   ext_status,
  // Results
  output logic                                   skip,
  output logic [15:0]                            status_word
);

  function automatic logic flag_test(input logic [1:0] t, input logic b, input logic d);
    logic r;
    r = 1'b0;
    unique case (iocfp_pkg::iocfp_test_type'(t))
      iocfp_pkg::test_busy_set:   r = b;
      iocfp_pkg::test_busy_clear: r = !b;
      iocfp_pkg::test_done_set:   r = d;
      iocfp_pkg::test_done_clear: r = !d;
    endcase
    return r;
  endfunction

  assign skip = flag_test(test, busy, done);

  always_comb begin
    status_word = 16'h0000;
    status_word[iocfp_pkg::STW_ACT_ERR]  = act_err;
    status_word[iocfp_pkg::STW_PASS_ERR] = pass_err;
    status_word[iocfp_pkg::STW_EXT_LSB +: iocfp_pkg::STW_EXT_W] = ext_status;
  end

endmodule // iocfp_status

// File: rtl/iocfp_top.sv
// Purpose: Peripheral controller front end with busy/done flags, behind APB.
// Assumes: Software writes the accumulator value, then the instruction word.
// Notes:   Flag commands act one cycle after the instruction is taken.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Only words whose top three bits are 011 count as instructions.
// - Decode accumulator, opcode, flag field and device code from fixed bit fields.
// - Respond only when the 6-bit device code matches our own.
// - Never answer code zero or the all-ones processor code.
// - Start sets busy, clears done, launches the operation; zero field does nothing.
// - Clear forces busy and done to zero, idling the peripheral.
// - Pulse gives the peripheral a one-cycle special-action strobe.
// - Busy holds for the operation; completion clears busy and sets done.
// - Interrupt request only while done is one.
// - Skip test selects busy set, busy clear, done set or done clear.
// - Opcodes 000 and 111 move no data.
// - Opcodes 001, 011, 101 read input buffers A, B, C.
// - Opcodes 010, 100, 110 load output buffers A, B, C.
// - Flag command of a transfer acts only after the transfer.
// - Other status flags sit at fixed bits of a 16-bit status word.
// - Passive error sets during an operation; operation still completes normally.
// - Start of disallowed operation: no start, set active error and done.
// - Non-transfer instructions ignore the accumulator selector, touch no accumulator.
// - Unused bits ignored on write and read back as zero.
module iocfp_top #(
  parameter int         DATA_W      = 16,
  parameter logic [5:0] DEVICE_CODE = 6'h0a
) (
  // Clock and reset
  input  wire logic                              CORE_CLK,
  input  wire logic                              RST,
  // APB slave
  input  wire logic                              PSEL,
  input  wire logic                              PENABLE,
  input  wire logic                              PWRITE,
  input  wire logic [7:0]                        PADDR,
  input  wire logic [31:0]                       PWDATA,
  output logic [31:0]                            PRDATA,
  output logic                                   PREADY,
  output logic                                   PSLVERR,
  // Peripheral data
  input  wire logic [DATA_W-1:0]                 IN_BUF_A,
  input  wire logic [DATA_W-1:0]                 IN_BUF_B,
  input  wire logic [iocfp_pkg::STW_EXT_W-1:0]   IN_STATUS_EXT,
  output logic [DATA_W-1:0]                      OUT_BUF_A,
  output logic [DATA_W-1:0]                      OUT_BUF_B,
  output logic [DATA_W-1:0]                      OUT_BUF_C,
  output logic                                   OUT_LOAD_A,
  output logic                                   OUT_LOAD_B,
  output logic                                   OUT_LOAD_C,
  // Peripheral control
  output logic                                   START_OP,
  output logic                                   CLEAR_OP,
  output logic                                   PULSE_OP,
  input  wire logic                              OP_COMPLETE,
  input  wire logic                              OP_ILLEGAL,
  input  wire logic                              PASSIVE_ERR_IN,
  // Flags
  output logic                                   BUSY,
  output logic                                   DONE,
  output logic                                   INT_REQ
);

  if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
    $error("iocfp_top: DATA_W must be 1 to 16");
  end
  if (DEVICE_CODE == iocfp_pkg::DEV_NONE || DEVICE_CODE == iocfp_pkg::DEV_CPU) begin : g_bad_code
    $error("iocfp_top: DEVICE_CODE may not be zero or all ones");
  end

  typedef struct packed {
    logic              busy;
    logic              done;
    logic              act_err;
    logic              pass_err;
    logic              skip;
    logic [1:0]        acc_sel;
    logic              pend;
    logic [1:0]        pend_cmd;
    logic [15:0]       acc_in;
    logic [15:0]       acc_out;
    logic [5:0]        devcode;
    logic [DATA_W-1:0] obuf_a;
    logic [DATA_W-1:0] obuf_b;
    logic [DATA_W-1:0] obuf_c;
    logic              start_p;
    logic              clear_p;
    logic              pulse_p;
    logic              load_a;
    logic              load_b;
    logic              load_c;
  } iocfp_state_type;

  iocfp_state_type q;
  iocfp_state_type d;

  // Narrow buffers sit in the low bits, the rest reads as zero
  function automatic logic [15:0] widen(input logic [DATA_W-1:0] v);
    logic [15:0] r;
    r = 16'h0000;
    r[DATA_W-1:0] = v;
    return r;
  endfunction

  logic                          hit;
  iocfp_pkg::iocfp_opcode_type   opcode;
  logic [1:0]                    fcmd;
  logic [1:0]                    acc_sel;
  logic                          skip_now;
  logic [15:0]                   status_word;
  logic                          setup;
  logic                          access;
  logic                          wr_en;
  logic [7:0]                    word_addr;
  logic                          mapped;
  logic                          instr_wr;

  iocfp_decode u_decode (
    .instr   (PWDATA[15:0]),
    .devcode (q.devcode),
    .hit     (hit),
    .opcode  (opcode),
    .fcmd    (fcmd),
    .acc_sel (acc_sel)
  );

  iocfp_status u_status (
    .busy        (q.busy),
    .done        (q.done),
    .act_err     (q.act_err),
    .pass_err    (q.pass_err),
    .test        (fcmd),
    .ext_status  (IN_STATUS_EXT),
    .skip        (skip_now),
    .status_word (status_word)
  );

  assign setup     = PSEL && !PENABLE;
  assign access    = PSEL && PENABLE;
  assign word_addr = {PADDR[7:2], 2'b00};
  assign mapped    = (word_addr == iocfp_pkg::ADDR_INSTR)   ||
                     (word_addr == iocfp_pkg::ADDR_ACC_OUT) ||
                     (word_addr == iocfp_pkg::ADDR_ACC_IN)  ||
                     (word_addr == iocfp_pkg::ADDR_FLAGS)   ||
                     (word_addr == iocfp_pkg::ADDR_DEVCODE);
  assign wr_en     = access && PWRITE && PREADY && mapped;
  assign instr_wr  = wr_en && (word_addr == iocfp_pkg::ADDR_INSTR);

  // A waiting flag command stalls the bus so two never overlap
  assign PREADY  = !q.pend;
  assign PSLVERR = access && PREADY && !mapped;

  always_comb begin
    PRDATA = 32'h0000_0000;
    if (access && !PWRITE) begin
      unique case (word_addr)
        iocfp_pkg::ADDR_ACC_OUT: PRDATA[15:0] = q.acc_out;
        iocfp_pkg::ADDR_ACC_IN:  PRDATA[15:0] = q.acc_in;
        iocfp_pkg::ADDR_FLAGS: begin
          PRDATA[iocfp_pkg::FLG_BUSY]     = q.busy;
          PRDATA[iocfp_pkg::FLG_DONE]     = q.done;
          PRDATA[iocfp_pkg::FLG_SKIP]     = q.skip;
          PRDATA[iocfp_pkg::FLG_PASS_ERR] = q.pass_err;
          PRDATA[iocfp_pkg::FLG_ACT_ERR]  = q.act_err;
          PRDATA[iocfp_pkg::FLG_PEND]     = q.pend;
          PRDATA[iocfp_pkg::FLG_ACC_LSB +: 2] = q.acc_sel;
        end
        iocfp_pkg::ADDR_DEVCODE: PRDATA[5:0] = q.devcode;
        default:                 PRDATA = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    d         = q;
    d.start_p = 1'b0;
    d.clear_p = 1'b0;
    d.pulse_p = 1'b0;
    d.load_a  = 1'b0;
    d.load_b  = 1'b0;
    d.load_c  = 1'b0;
    d.pend    = 1'b0;

    if (q.busy && OP_COMPLETE) begin
      d.busy = 1'b0;
      d.done = 1'b1;
    end

    // Command left over from the previous cycle's instruction
    if (q.pend) begin
      unique case (iocfp_pkg::iocfp_flag_type'(q.pend_cmd))
        iocfp_pkg::FLAG_START: begin
          if (OP_ILLEGAL) begin
            d.busy    = 1'b0;
            d.done    = 1'b1;
            d.act_err = 1'b1;
          end else begin
            d.busy     = 1'b1;
            d.done     = 1'b0;
            d.act_err  = 1'b0;
            d.pass_err = 1'b0;
            d.start_p  = 1'b1;
          end
        end
        iocfp_pkg::FLAG_CLEAR: begin
          d.busy    = 1'b0;
          d.done    = 1'b0;
          d.clear_p = 1'b1;
        end
        iocfp_pkg::FLAG_PULSE: d.pulse_p = 1'b1;
        iocfp_pkg::FLAG_NONE:  d.pulse_p = 1'b0;
      endcase
    end

    // An error in the same cycle as a restart still counts
    if (q.busy && PASSIVE_ERR_IN) begin
      d.pass_err = 1'b1;
    end

    if (wr_en && word_addr == iocfp_pkg::ADDR_ACC_OUT) begin
      d.acc_out = PWDATA[15:0];
    end
    if (wr_en && word_addr == iocfp_pkg::ADDR_DEVCODE &&
        PWDATA[5:0] != iocfp_pkg::DEV_NONE && PWDATA[5:0] != iocfp_pkg::DEV_CPU) begin
      d.devcode = PWDATA[5:0];
    end

    if (instr_wr && hit) begin
      // Transfer happens now; any flag command waits one cycle
      d.pend     = (opcode != iocfp_pkg::skip_on_flag_test) &&
                   (fcmd != iocfp_pkg::FLAG_NONE);
      d.pend_cmd = fcmd;
      unique case (opcode)
        iocfp_pkg::flag_command_only: d.pend_cmd = fcmd;
        iocfp_pkg::skip_on_flag_test: d.skip = skip_now;
        iocfp_pkg::read_input_buffer_a: begin
          d.acc_in  = widen(IN_BUF_A);
          d.acc_sel = acc_sel;
        end
        iocfp_pkg::read_input_buffer_b: begin
          d.acc_in  = widen(IN_BUF_B);
          d.acc_sel = acc_sel;
        end
        iocfp_pkg::read_input_buffer_c: begin
          d.acc_in  = status_word;
          d.acc_sel = acc_sel;
        end
        iocfp_pkg::write_output_buffer_a: begin
          d.obuf_a  = q.acc_out[DATA_W-1:0];
          d.load_a  = 1'b1;
          d.acc_sel = acc_sel;
        end
        iocfp_pkg::write_output_buffer_b: begin
          d.obuf_b  = q.acc_out[DATA_W-1:0];
          d.load_b  = 1'b1;
          d.acc_sel = acc_sel;
        end
        iocfp_pkg::write_output_buffer_c: begin
          d.obuf_c  = q.acc_out[DATA_W-1:0];
          d.load_c  = 1'b1;
          d.acc_sel = acc_sel;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      q         <= '0;
      q.devcode <= DEVICE_CODE;
    end else begin
      q         <= d;
    end
  end

  assign BUSY       = q.busy;
  assign DONE       = q.done;
  assign INT_REQ    = q.done;
  assign START_OP   = q.start_p;
  assign CLEAR_OP   = q.clear_p;
  assign PULSE_OP   = q.pulse_p;
  assign OUT_BUF_A  = q.obuf_a;
  assign OUT_BUF_B  = q.obuf_b;
  assign OUT_BUF_C  = q.obuf_c;
  assign OUT_LOAD_A = q.load_a;
  assign OUT_LOAD_B = q.load_b;
  assign OUT_LOAD_C = q.load_c;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  a_foreign_ignored: assert property (
    instr_wr && !hit |=> !q.pend && $stable(OUT_BUF_A) && $stable(q.acc_in))
    else $error("foreign word changed controller state");

  a_code_legal: assert property (
    q.devcode != iocfp_pkg::DEV_NONE && q.devcode != iocfp_pkg::DEV_CPU)
    else $error("reserved device code accepted");

  a_start_busy: assert property (
    q.pend && q.pend_cmd == iocfp_pkg::FLAG_START && !OP_ILLEGAL
    |=> BUSY && !DONE && START_OP ##1 !START_OP)
    else $error("start did not launch operation");

  a_clear_idle: assert property (
    q.pend && q.pend_cmd == iocfp_pkg::FLAG_CLEAR |=> !BUSY && !DONE && CLEAR_OP)
    else $error("clear did not idle peripheral");

  a_pulse_only: assert property (
    q.pend && q.pend_cmd == iocfp_pkg::FLAG_PULSE
    |=> PULSE_OP && !START_OP && !CLEAR_OP)
    else $error("pulse command misbehaved");

  a_complete_done: assert property (
    BUSY && OP_COMPLETE && !q.pend |=> !BUSY && DONE)
    else $error("completion did not set done");

  a_irq_done: assert property (
    $rose(INT_REQ) |-> $rose(DONE) && !$past(DONE))
    else $error("interrupt without done");

  a_skip_value: assert property (
    instr_wr && hit && opcode == iocfp_pkg::skip_on_flag_test && fcmd == 2'h2 &&
    !(BUSY && OP_COMPLETE)
    |=> q.skip == $past(q.done) && $stable(BUSY))
    else $error("skip test wrong");

  a_read_a: assert property (
    instr_wr && hit && opcode == iocfp_pkg::read_input_buffer_a
    |=> q.acc_in == widen($past(IN_BUF_A)))
    else $error("input buffer A not returned");

  a_write_b: assert property (
    instr_wr && hit && opcode == iocfp_pkg::write_output_buffer_b
    |=> OUT_BUF_B == $past(q.acc_out[DATA_W-1:0]) && OUT_LOAD_B)
    else $error("output buffer B not loaded");

  a_flag_after: assert property (
    instr_wr && hit && opcode == iocfp_pkg::write_output_buffer_a &&
    fcmd == iocfp_pkg::FLAG_START |=> OUT_LOAD_A && !START_OP ##1 (START_OP || DONE))
    else $error("flag command not after transfer");

  a_illegal_start: assert property (
    q.pend && q.pend_cmd == iocfp_pkg::FLAG_START && OP_ILLEGAL
    |=> DONE && !BUSY && q.act_err && !START_OP)
    else $error("disallowed start not refused");

  a_passive_err: assert property (
    BUSY && PASSIVE_ERR_IN |=> q.pass_err)
    else $error("passive error lost");

endmodule // iocfp_top

// File: verif/iocfp_periph_model.sv
// Purpose: Peripheral behind the flag port: finishes a started operation after DELAY cycles.
// Assumes: START_OP, CLEAR_OP and PULSE_OP are one-cycle pulses.
// Notes:   A clear cancels a pending finish, so a stale completion cannot set done.
`timescale 1ns/1ps
module iocfp_periph_model #(
  parameter int         DELAY = 20,
  parameter logic [13:0] EXT  = 14'h2a5
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // From the controller
  input  wire logic        start_op,
  input  wire logic        clear_op,
  input  wire logic        pulse_op,
  input  wire logic        busy,
  // Scenario knobs
  input  wire logic        cfg_illegal,
  input  wire logic        cfg_perr,
  // To the controller
  output logic [15:0]      in_buf_a,
  output logic [15:0]      in_buf_b,
  output logic [13:0]      status_ext,
  output logic             op_complete,
  output logic             op_illegal,
  output logic             passive_err,
  // Observed pulse counts
  output logic [7:0]       start_cnt,
  output logic [7:0]       pulse_cnt
);
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] starts;
    logic [7:0] pulses;
    logic       complete;
    logic       illegal;
    logic       perr;
  } iocfp_model_state_type;
  iocfp_model_state_type state_q;
  iocfp_model_state_type state_d;
  assign in_buf_a    = 16'h5a3c;
  assign in_buf_b    = 16'hc3a5;
  assign status_ext  = EXT;
  assign op_complete = state_q.complete;
  assign op_illegal  = state_q.illegal;
  assign passive_err = state_q.perr;
  assign start_cnt   = state_q.starts;
  assign pulse_cnt   = state_q.pulses;
  always_comb begin
    state_d          = state_q;
    state_d.complete = 1'b0;
    state_d.illegal  = cfg_illegal;
    state_d.perr     = cfg_perr & busy;
    if (start_op) begin
      state_d.starts = state_q.starts + 8'h01;
      state_d.cnt    = 8'(DELAY);
    end else if (clear_op) begin
      state_d.cnt = 8'h00;
    end else if (state_q.cnt == 8'h01) begin
      state_d.complete = 1'b1;
      state_d.cnt      = 8'h00;
    end else if (state_q.cnt != 8'h00) begin
      state_d.cnt = state_q.cnt - 8'h01;
    end
    if (pulse_op) begin
      state_d.pulses = state_q.pulses + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    state_q <= rst ? '0 : state_d;
  end
endmodule // iocfp_periph_model

// File: verif/tb_top.sv
// Purpose: Self-checking bench driving instructions over APB.
// Assumes: Device code left at its default of 6'h0a.
// Notes:   At least one idle cycle between APB transfers.
`timescale 1ns/1ps
module tb_top;
  localparam logic [13:0] EXT_V = 14'h2a5;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, es, cfg_ill = 1'b0, cfg_perr = 1'b0;
  logic [15:0] ia, ib, oa, ob, oc;
  logic [13:0] ext;
  logic        la, lb, lc, st, cl, pu, cmp, ill, perr, busy, done, irq;
  logic [7:0]  starts, pulses;
  logic [7:0]  n_la = 8'h00, n_lb = 8'h00, n_lc = 8'h00, n_cl = 8'h00;
  int          err_total = 0, checked = 0, cycles = 0;
  iocfp_top u_dut (.CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IN_BUF_A(ia), .IN_BUF_B(ib), .IN_STATUS_EXT(ext), .OUT_BUF_A(oa),
    .OUT_BUF_B(ob), .OUT_BUF_C(oc), .OUT_LOAD_A(la), .OUT_LOAD_B(lb), .OUT_LOAD_C(lc),
    .START_OP(st), .CLEAR_OP(cl), .PULSE_OP(pu), .OP_COMPLETE(cmp), .OP_ILLEGAL(ill),
    .PASSIVE_ERR_IN(perr), .BUSY(busy), .DONE(done), .INT_REQ(irq));
  iocfp_periph_model #(.DELAY(20), .EXT(EXT_V)) u_model (.clk(core_clk), .rst(rst),
    .start_op(st), .clear_op(cl), .pulse_op(pu), .busy(busy), .cfg_illegal(cfg_ill),
    .cfg_perr(cfg_perr), .in_buf_a(ia), .in_buf_b(ib), .status_ext(ext),
    .op_complete(cmp), .op_illegal(ill), .passive_err(perr), .start_cnt(starts),
    .pulse_cnt(pulses));
  always #20 core_clk = ~core_clk;
  // Count load and clear strobes so single-cycle pulses are not missed
  always @(posedge core_clk) begin
    if (!rst) begin
      n_la <= n_la + {7'h00, la};
      n_lb <= n_lb + {7'h00, lb};
      n_lc <= n_lc + {7'h00, lc};
      n_cl <= n_cl + {7'h00, cl};
    end
  end
  task automatic complete_run;
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Request held from setup until the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    es = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Three cycles let the flag command and its pulse land
  task automatic ins(input logic [2:0] op, input logic [1:0] f, input logic [1:0] ac);
    apb(1'b1, iocfp_pkg::ADDR_INSTR, {16'h0, 3'h3, ac, op, f, 6'h0a});
    repeat (3) @(posedge core_clk);
  endtask
  task automatic wait_done;
    for (int n = 0; n < 100 && done !== 1'b1; n++) @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, iocfp_pkg::ADDR_FLAGS, 32'h0);
    chk("flags_rst", r, 32'h0);
    chk("irq_rst", 32'(irq), 32'h0);
    apb(1'b1, iocfp_pkg::ADDR_DEVCODE, 32'h0);
    apb(1'b0, iocfp_pkg::ADDR_DEVCODE, 32'h0);
    chk("devcode_zero", r, 32'h0a);
    apb(1'b1, iocfp_pkg::ADDR_ACC_OUT, 32'hffff1234);
    ins(iocfp_pkg::write_output_buffer_a, iocfp_pkg::FLAG_START, 2'h1);
    chk("out_a", 32'(oa), 32'h1234);
    chk("busy_start", 32'({busy, done}), 32'h2);
    ins(iocfp_pkg::skip_on_flag_test, iocfp_pkg::test_busy_set, 2'h3);
    apb(1'b0, iocfp_pkg::ADDR_FLAGS, 32'h0);
    chk("skip_busy", 32'(r[2]), 32'h1);
    chk("acc_kept", 32'(r[7:6]), 32'h1);
    chk("busy_hold", 32'({busy, done}), 32'h2);
    wait_done();
    chk("finish", 32'({busy, done, irq}), 32'h3);
    for (int t = 0; t < 4; t++) begin
      ins(iocfp_pkg::skip_on_flag_test, 2'(t), 2'h0);
      apb(1'b0, iocfp_pkg::ADDR_FLAGS, 32'h0);
      chk("skip_table", 32'(r[2]), 32'((4'b0110 >> t) & 4'h1));
    end
    ins(iocfp_pkg::flag_command_only, iocfp_pkg::FLAG_PULSE, 2'h0);
    chk("pulse", 32'({pulses, busy, done}), 32'h5);
    ins(iocfp_pkg::flag_command_only, iocfp_pkg::FLAG_NONE, 2'h0);
    chk("no_cmd", 32'({starts, busy, done}), 32'h5);
    ins(iocfp_pkg::flag_command_only, iocfp_pkg::FLAG_CLEAR, 2'h0);
    chk("clear", 32'({n_cl, busy, done, irq}), 32'h8);
    apb(1'b1, iocfp_pkg::ADDR_INSTR, {16'h0, 3'h2, 5'h0, 2'h1, 6'h0a});
    apb(1'b1, iocfp_pkg::ADDR_INSTR, {16'h0, 3'h3, 5'h0, 2'h1, 6'h0b});
    apb(1'b1, iocfp_pkg::ADDR_INSTR, {16'h0, 3'h3, 5'h0, 2'h1, 6'h00});
    repeat (3) @(posedge core_clk);
    chk("ignored", 32'({starts, busy}), 32'h2);
    ins(iocfp_pkg::read_input_buffer_a, iocfp_pkg::FLAG_NONE, 2'h2);
    apb(1'b0, iocfp_pkg::ADDR_ACC_IN, 32'h0);
    chk("in_a", r, 32'h5a3c);
    apb(1'b0, iocfp_pkg::ADDR_FLAGS, 32'h0);
    chk("acc_sel", 32'(r[7:6]), 32'h2);
    ins(iocfp_pkg::read_input_buffer_b, iocfp_pkg::FLAG_NONE, 2'h0);
    apb(1'b0, iocfp_pkg::ADDR_ACC_IN, 32'h0);
    chk("in_b", r, 32'hc3a5);
    apb(1'b1, iocfp_pkg::ADDR_ACC_OUT, 32'h0000beef);
    ins(iocfp_pkg::write_output_buffer_b, iocfp_pkg::FLAG_NONE, 2'h0);
    apb(1'b1, iocfp_pkg::ADDR_ACC_OUT, 32'h00007777);
    ins(iocfp_pkg::write_output_buffer_c, iocfp_pkg::FLAG_NONE, 2'h0);
    chk("out_bc", {ob, oc}, 32'hbeef7777);
    chk("loads", 32'({n_la, n_lb, n_lc}), 32'h010101);
    cfg_ill <= 1'b1;
    ins(iocfp_pkg::flag_command_only, iocfp_pkg::FLAG_START, 2'h0);
    chk("illegal", 32'({starts, busy, done}), 32'h5);
    apb(1'b0, iocfp_pkg::ADDR_FLAGS, 32'h0);
    chk("act_err", 32'(r[4]), 32'h1);
    cfg_ill <= 1'b0;
    cfg_perr <= 1'b1;
    ins(iocfp_pkg::flag_command_only, iocfp_pkg::FLAG_START, 2'h0);
    chk("perr_run", 32'({busy, done}), 32'h2);
    wait_done();
    chk("perr_done", 32'({busy, done}), 32'h1);
    cfg_perr <= 1'b0;
    ins(iocfp_pkg::read_input_buffer_c, iocfp_pkg::FLAG_NONE, 2'h0);
    apb(1'b0, iocfp_pkg::ADDR_ACC_IN, 32'h0);
    chk("status_word", r, {16'h0, EXT_V, 2'h2});
    ins(iocfp_pkg::flag_command_only, iocfp_pkg::FLAG_START, 2'h0);
    ins(iocfp_pkg::flag_command_only, iocfp_pkg::FLAG_CLEAR, 2'h0);
    repeat (30) @(posedge core_clk);
    chk("clear_mid", 32'({n_cl, busy, done}), 32'h8);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {r[30:0], es}, 32'h1);
    complete_run();
  end
endmodule // tb_top
